// >>> hdl/mcr_frame.sv
`timescale 1ns/1ps
// Purpose: Mainframe end: reads card ID bytes, loads relay chain
// Assumes: Single clock; user words pass a two-entry buffer
// Notes:   Words of CHAIN_BITS are sent MSB first then strobed
module mcr_frame (
  input  wire logic                          mclk_i,
  input  wire logic                          sys_rst_i,
  mcr_link_if.frame                          link,
  input  wire logic                          id_start_i,
  input  wire logic [mcr_pkg::ADDR_BITS-1:0] id_count_i,
  output logic [7:0]                         id_byte_o,
  output logic                               id_valid_o,
  input  wire logic                          id_ready_i,
  input  wire logic [mcr_pkg::CHAIN_BITS-1:0] cfg_word_i,
  input  wire logic                          cfg_valid_i,
  output logic                               cfg_ready_o,
  output logic                               busy_o
);
  localparam int CB = mcr_pkg::CHAIN_BITS;
  typedef enum logic [2:0] {S_IDLE, S_CLR, S_ADV, S_BIT, S_HOLD, S_RLY, S_STB} mcr_state_e;

  mcr_state_e    st, next_st;
  logic [CB-1:0] buf_d [2];
  logic [CB-1:0] next_buf0, next_buf1;
  logic [1:0]    cnt, next_cnt;
  logic [CB-1:0] sh, next_sh;
  logic [6:0]    bits, next_bits;
  logic [3:0]    bytes, next_bytes;
  logic [7:0]    rx, next_rx;
  logic [7:0]    id_q, next_id_q;
  logic          idv, next_idv;
  logic [1:0]    div, next_div;
  logic          lclk, next_lclk, sel_n, next_sel_n, clr, next_clr, adv_n, next_adv_n;
  logic          pop;

  assign cfg_ready_o = (cnt != 2'h2);
  assign id_byte_o   = id_q;
  assign id_valid_o  = idv;
  assign busy_o      = (st != S_IDLE);
  assign link.link_clk          = lclk;
  assign link.card_select_n     = sel_n;
  assign link.id_address_clear  = clr;
  assign link.id_address_next_n = adv_n;
  assign link.relay_data        = sh[CB-1];
  assign link.relay_strobe      = (st == S_STB);
  assign pop = (st == S_IDLE) && (cnt != 2'h0) && !id_start_i;

  always_comb begin
    next_buf0 = buf_d[0];
    next_buf1 = buf_d[1];
    next_cnt  = cnt;
    if (pop) begin
      next_buf0 = buf_d[1];
      next_cnt  = cnt - 2'h1;
    end
    if (cfg_valid_i && cfg_ready_o) begin
      if (next_cnt == 2'h0) next_buf0 = cfg_word_i;
      else next_buf1 = cfg_word_i;
      next_cnt = next_cnt + 2'h1;
    end
  end

  always_comb begin
    next_st = st; next_sh = sh; next_bits = bits; next_bytes = bytes; next_rx = rx;
    next_id_q = id_q; next_idv = idv && !id_ready_i; next_div = div + 2'h1;
    next_lclk = lclk; next_sel_n = sel_n; next_clr = 1'b0; next_adv_n = 1'b1;
    case (st)
      S_IDLE: begin
        next_div = '0; next_lclk = 1'b0;
        if (id_start_i) begin
          next_sel_n = 1'b0; next_clr = 1'b1;
          next_bytes = id_count_i; next_st = S_CLR;
        end else if (pop) begin
          next_sh = buf_d[0]; next_bits = 7'(CB); next_st = S_RLY;
        end
      end
      S_CLR: next_st = S_ADV;
      S_ADV: begin
        if (bytes == 4'h0 || idv) begin
          if (bytes == 4'h0) begin next_sel_n = 1'b1; next_st = S_IDLE; end
        end else begin
          next_adv_n = 1'b0; next_bits = 7'h08; next_st = S_HOLD;
        end
      end
      S_HOLD: begin next_div = '0; next_st = S_BIT; end
      S_BIT: begin
        if (div == 2'(mcr_pkg::LINK_HALF - 1)) begin
          next_div = '0; next_lclk = ~lclk;
          if (!lclk) next_rx = {rx[6:0], link.id_serial_out};
          else if (bits == 7'h01) begin
            next_id_q = rx; next_idv = 1'b1; next_bytes = bytes - 4'h1; next_st = S_ADV;
          end else next_bits = bits - 7'h01;
        end
      end
      S_RLY: begin
        if (div == 2'(mcr_pkg::LINK_HALF - 1)) begin
          next_div = '0; next_lclk = ~lclk;
          if (lclk) begin
            next_sh = {sh[CB-2:0], 1'b0};
            if (bits == 7'h01) next_st = S_STB; else next_bits = bits - 7'h01;
          end
        end
      end
      S_STB: next_st = S_IDLE;
      default: next_st = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st <= S_IDLE; buf_d[0] <= '0; buf_d[1] <= '0; cnt <= '0; sh <= '0; bits <= '0;
      bytes <= '0; rx <= '0; id_q <= '0; idv <= 1'b0; div <= '0; lclk <= 1'b0;
      sel_n <= 1'b1; clr <= 1'b0; adv_n <= 1'b1;
    end else begin
      st <= next_st; buf_d[0] <= next_buf0; buf_d[1] <= next_buf1; cnt <= next_cnt;
      sh <= next_sh; bits <= next_bits; bytes <= next_bytes; rx <= next_rx;
      id_q <= next_id_q; idv <= next_idv; div <= next_div; lclk <= next_lclk;
      sel_n <= next_sel_n; clr <= next_clr; adv_n <= next_adv_n;
    end
  end
endmodule

// >>> hdl/mcr_pkg.sv
// Purpose: Shared constants for the matrix card identification and relay load link
// Assumes: One clock domain, mclk_i at 200 MHz
// Notes:   Relay chain is twelve eight-bit driver stages
package mcr_pkg;
  localparam int          NUM_STAGES   = 12;
  localparam int          STAGE_BITS   = 8;
  localparam int          CHAIN_BITS   = NUM_STAGES * STAGE_BITS;
  localparam int          ROM_DEPTH    = 16;
  localparam int          ADDR_BITS    = 4;
  localparam int          CLK_PERIOD_NS = 5;
  // Settle time of the power-up guard, in ns
  localparam int          GUARD_NS     = 1000;
  localparam int          GUARD_CYCLES = GUARD_NS / CLK_PERIOD_NS;
  localparam int          GUARD_BITS   = 8;
  // Link bit clock divider: half period in mclk cycles
  localparam int          LINK_HALF    = 2;
  localparam logic [3:0]  BIT_LAST     = 4'h7;
  localparam logic [7:0]  RESET_BYTE   = 8'h00;
  // Identification content; values are arbitrary
  localparam logic [7:0]  CARD_TYPE_ID = 8'h5A;
  localparam logic [7:0]  CARD_REV_ID  = 8'h01;
endpackage

// >>> hdl/mcr_link_if.sv
`timescale 1ns/1ps
// Purpose: Backplane signals between mainframe and matrix card
// Assumes: Single clock; link_clk is a data-rate strobe sampled on mclk_i
// Notes:   Mainframe drives all lines except id_serial_out
interface mcr_link_if;
  logic card_select_n;
  logic id_address_clear;
  logic id_address_next_n;
  logic link_clk;
  logic id_serial_out;
  logic relay_data;
  logic relay_strobe;
  modport card  (input card_select_n, id_address_clear, id_address_next_n, link_clk,
                 relay_data, relay_strobe, output id_serial_out);
  modport frame (output card_select_n, id_address_clear, id_address_next_n, link_clk,
                 relay_data, relay_strobe, input id_serial_out);
endinterface

// >>> hdl/mcr_card.sv
`timescale 1ns/1ps
// Purpose: Matrix card end: identification read-out and relay chain load
// Assumes: Link lines synchronous to mclk_i; link_clk rising edge marks a bit
// Notes:   Link lines sampled on mclk_i edges
// Contract
// - Card holds ID and table in ROM
// - Select low powers up; ROM only while selected
// - Address counter picks byte loaded into shifter
// - One ID bit shifted per link clock rising edge
// - Host keeps clear low after first byte
// - Relay data shifted into twelve stages
// - Relays change only on latch strobe
// - Drivers invert: one drives output low
// - Guard holds output enable inactive at power-up
// - First strobe after settle releases guard
// - Host pulses clear high at sequence start
// - Host pulses advance low before each byte
module mcr_card (
  input  wire logic                          mclk_i,
  input  wire logic                          sys_rst_i,
  mcr_link_if.card                           link,
  output logic [mcr_pkg::CHAIN_BITS-1:0]     relay_drive_n_o,
  output logic                               output_enable_n_o
);
  localparam int CB = mcr_pkg::CHAIN_BITS;

  function automatic logic [7:0] rom_byte(input logic [mcr_pkg::ADDR_BITS-1:0] a);
    case (a)
      4'h0:    rom_byte = mcr_pkg::CARD_TYPE_ID;
      4'h1:    rom_byte = mcr_pkg::CARD_REV_ID;
      4'h2:    rom_byte = 8'h08;
      4'h3:    rom_byte = 8'h0C;
      default: rom_byte = 8'hFF;
    endcase
  endfunction

  logic [mcr_pkg::ADDR_BITS-1:0]  addr, next_addr;
  logic [7:0]                     id_shift, next_id_shift;
  logic                           clk_d, next_clk_d;
  logic                           adv_d, next_adv_d;
  logic [CB-1:0]                  chain, next_chain;
  logic [CB-1:0]                  latched, next_latched;
  logic                           guard, next_guard;
  logic [mcr_pkg::GUARD_BITS-1:0] settle, next_settle;
  logic                           clk_rise;
  logic                           adv_fall;

  assign clk_rise = link.link_clk & ~clk_d;
  assign adv_fall = ~link.id_address_next_n & adv_d;

  always_comb begin
    next_clk_d    = link.link_clk;
    next_adv_d    = link.id_address_next_n;
    next_addr     = addr;
    next_id_shift = id_shift;
    if (link.id_address_clear) begin
      next_addr = '0;
    end else if (adv_fall && !link.card_select_n) begin
      next_id_shift = rom_byte(addr);
      next_addr     = addr + 4'h1;
    end else if (clk_rise && !link.card_select_n) begin
      next_id_shift = {id_shift[6:0], 1'b0};
    end
  end

  // ROM output only driven while selected
  assign link.id_serial_out = ~link.card_select_n & id_shift[7];

  always_comb begin
    next_chain   = chain;
    next_latched = latched;
    if (clk_rise) begin
      next_chain = {chain[CB-2:0], link.relay_data};
    end
    if (link.relay_strobe) begin
      next_latched = chain;
    end
  end

  always_comb begin
    next_settle = settle;
    next_guard  = guard;
    if (settle != mcr_pkg::GUARD_CYCLES[mcr_pkg::GUARD_BITS-1:0]) begin
      next_settle = settle + 8'h01;
    end else if (link.relay_strobe) begin
      next_guard = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      addr     <= '0;
      id_shift <= mcr_pkg::RESET_BYTE;
      clk_d    <= 1'b0;
      adv_d    <= 1'b1;
      chain    <= '0;
      latched  <= '0;
      guard    <= 1'b1;
      settle   <= '0;
    end else begin
      addr     <= next_addr;
      id_shift <= next_id_shift;
      clk_d    <= next_clk_d;
      adv_d    <= next_adv_d;
      chain    <= next_chain;
      latched  <= next_latched;
      guard    <= next_guard;
      settle   <= next_settle;
    end
  end

  assign output_enable_n_o = guard;
  // Disabled drivers float high: relay released
  assign relay_drive_n_o = guard ? {CB{1'b1}} : ~latched;
endmodule

// >>> test/mcr_link_props.sv
// Purpose: Link and relay output checks
// Assumes: One clock, sync reset high
// Notes:   Instantiated beside the link interface
`timescale 1ns/1ps
module mcr_link_props (
  input wire logic                          mclk_i,
  input wire logic                          sys_rst_i,
  input wire logic                          card_select_n,
  input wire logic                          id_address_clear,
  input wire logic                          id_address_next_n,
  input wire logic                          link_clk,
  input wire logic                          id_serial_out,
  input wire logic                          relay_data,
  input wire logic                          relay_strobe,
  input wire logic [mcr_pkg::CHAIN_BITS-1:0] relay_drive_n_o,
  input wire logic                          output_enable_n_o
);
  logic [3:0] stb_hist;
  logic [3:0] next_stb_hist;
  always_comb next_stb_hist = {stb_hist[2:0], relay_strobe};
  always_ff @(posedge mclk_i) stb_hist <= next_stb_hist;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  sequence clr_start_s;
    $fell(card_select_n) && id_address_clear;
  endsequence
  sequence next_step_s;
    !id_address_clear ##1 $fell(id_address_next_n);
  endsequence
  rst_guard_a: assert property (disable iff (1'h0) sys_rst_i |=> output_enable_n_o)
    else $error("guard not raised by reset");
  open_guard_a: assert property (output_enable_n_o |-> &relay_drive_n_o)
    else $error("relay energized while guarded");
  relay_hold_a: assert property ($changed(relay_drive_n_o) |-> (|stb_hist) || $past(sys_rst_i))
    else $error("relay outputs changed without strobe");
  guard_release_a: assert property ($fell(output_enable_n_o) |-> |stb_hist)
    else $error("guard released without strobe");
  id_deselect_a: assert property (card_select_n && $past(card_select_n, 2) |-> !id_serial_out)
    else $error("id line active while deselected");
  clr_pulse_a: assert property (id_address_clear |=> !id_address_clear)
    else $error("address clear longer than one cycle");
  next_pulse_a: assert property (!id_address_next_n |=> id_address_next_n)
    else $error("address advance longer than one cycle");
  id_order_a: assert property (clr_start_s |=> next_step_s)
    else $error("advance does not follow clear");
  clr_quiet_a: assert property ($fell(id_address_next_n) |=> !id_address_clear [*8])
    else $error("address clear during byte transfer");
  strobe_pulse_a: assert property (relay_strobe |=> !relay_strobe)
    else $error("strobe longer than one cycle");
endmodule

// >>> test/tb.sv
// Purpose: Card and mainframe ends joined, user sides driven
// Assumes: 200 MHz clock, sync reset high
// Notes:   Relay words random plus corner words
`timescale 1ns/1ps
module tb;
  logic mclk_i = 0, sys_rst_i = 1, id_start_i = 0, id_ready_i = 0, cfg_valid_i = 0;
  logic [3:0]  id_count_i = 4'h0;
  logic [95:0] cfg_word_i = '0, w, relay_drive_n_o;
  logic [7:0]  id_byte_o;
  logic        id_valid_o, cfg_ready_o, busy_o, output_enable_n_o;
  int          num_errors = 0, n_checks = 0, seed = 32'h2F20BAFD;
  mcr_link_if link ();
  mcr_card mcr_card_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .link(link.card),
    .relay_drive_n_o(relay_drive_n_o), .output_enable_n_o(output_enable_n_o));
  mcr_frame mcr_frame_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .link(link.frame),
    .id_start_i(id_start_i), .id_count_i(id_count_i), .id_byte_o(id_byte_o),
    .id_valid_o(id_valid_o), .id_ready_i(id_ready_i), .cfg_word_i(cfg_word_i),
    .cfg_valid_i(cfg_valid_i), .cfg_ready_o(cfg_ready_o), .busy_o(busy_o));
  mcr_link_props mcr_link_props_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .card_select_n(link.card_select_n), .id_address_clear(link.id_address_clear),
    .id_address_next_n(link.id_address_next_n), .link_clk(link.link_clk),
    .id_serial_out(link.id_serial_out), .relay_data(link.relay_data),
    .relay_strobe(link.relay_strobe), .relay_drive_n_o(relay_drive_n_o),
    .output_enable_n_o(output_enable_n_o));
  function automatic logic [7:0] rom_byte(input int a);
    return a == 0 ? mcr_pkg::CARD_TYPE_ID : a == 1 ? mcr_pkg::CARD_REV_ID :
           a == 2 ? 8'h08 : a == 3 ? 8'h0C : 8'hFF;
  endfunction
  task automatic chk(input string nm, input logic [95:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic read_id(input int n);
    int k;
    id_count_i = n[3:0];
    id_start_i = 1;
    @(posedge mclk_i);
    #1 id_start_i = 0;
    for (int b = 0; b < n; b++) begin
      k = 0;
      do @(negedge mclk_i); while (id_valid_o !== 1'h1 && ++k < 500);
      chk("id_byte", rom_byte(b), id_byte_o);
      repeat ($unsigned($random(seed)) % 4) @(posedge mclk_i);
      @(posedge mclk_i);
      #1 id_ready_i = 1;
      @(posedge mclk_i);
      #1 id_ready_i = 0;
    end
  endtask
  task automatic load(input logic [95:0] v);
    cfg_word_i = v;
    cfg_valid_i = 1;
    do @(negedge mclk_i); while (cfg_ready_o !== 1'h1);
    @(posedge mclk_i);
    #1 cfg_valid_i = 0;
    cfg_word_i = ~v;
    @(posedge mclk_i);
    #1;
  endtask
  task automatic settle(input logic [95:0] v);
    int k = 0;
    int idle = 0;
    while (idle < 2 && k < 2000) begin
      @(negedge mclk_i);
      idle = (busy_o === 1'h0) ? idle + 1 : 0;
      k++;
    end
    repeat (4) @(posedge mclk_i);
    #1 chk("relay_drive", ~v, relay_drive_n_o);
    chk("enable_n", 0, output_enable_n_o);
  endtask
  initial forever #2.5 mclk_i = ~mclk_i;
  initial begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge mclk_i);
    #1 sys_rst_i = 0;
    chk("enable_n", 1, output_enable_n_o);
    chk("relay_drive", '1, relay_drive_n_o);
    read_id(5);
    $display("test id read done");
    load(96'h1);
    load('1);
    settle('1);
    $display("test back to back done");
    for (int i = 0; i < 6; i++) begin
      w = {$random(seed), $random(seed), $random(seed)};
      w = i == 0 ? 96'h1 : i == 1 ? {1'h1, 95'h0} : w;
      load(w);
      settle(w);
    end
    $display("test relay words done");
    sys_rst_i = 1;
    repeat (3) @(posedge mclk_i);
    #1 sys_rst_i = 0;
    chk("enable_n", 1, output_enable_n_o);
    load(w);
    settle(w);
    $display("test second reset done");
    final_report();
  end
endmodule
